// ==== design/cpss_core.v ====
// What this block does
// R01: valid key opens four-instruction unlock window
// R02: unlock window holds off all interrupts
// R03: bit0 reads one during io unlock
// R04: bit1 reads one during spm unlock
// R05: reset loads stack pointer with sram top
// R06: only implemented stack bits, rest zero
// R07: low byte base, high byte next offset
// R08: low write blocks irqs up to four instrs, ended early by any other io write or a data write; a new low write restarts it
// R09: global enable bit gates all interrupts
// R10: irq entry and return leave enable alone
// R11: enable/disable instructions set/clear enable bit
// R12: io write changing enable inserts wait
// R13: transfer bit used by bit load/store
// R14: half carry from alu nibble carry
// R15: sign equals negative xor overflow
// R16: overflow flag from alu overflow
// R17: negative flag from alu result
// R18: zero flag from alu result
// R19: carry flag from alu carry
// R20: io unlock ends on memory access/sleep
// R21: low byte write goes to temp byte
// R22: invalid key opens nothing, reads zero; code leaves an already open window open, so it still reads its bit
`timescale 1ns/10ps
`include "cpss_defs.vh"
module cpss_core #(
  parameter SP_BITS = 8,
  parameter [15:0] SRAM_TOP = 16'h00ff
) (
  // clock and reset
  input wire CLK_I,
  input wire SRST_I,
  // io bus
  input wire IO_WE_I,
  input wire IO_RE_I,
  input wire [5:0] IO_ADDR_I,
  input wire [7:0] IO_WDATA_I,
  output reg [7:0] IO_RDATA_O,
  output reg IO_WAIT_O,
  // execution events
  input wire INSTR_DONE_I,
  input wire DMEM_WE_I,
  input wire NVM_ACCESS_I,
  input wire SLEEP_I,
  input wire IRQ_ENABLE_INSTR_I,
  input wire IRQ_DISABLE_INSTR_I,
  input wire BIT_STORE_INSTR_I,
  input wire BIT_STORE_VAL_I,
  // alu flag update
  input wire ALU_UPD_I,
  input wire [4:0] ALU_UPD_MASK_I,
  input wire ALU_H_I,
  input wire ALU_V_I,
  input wire ALU_N_I,
  input wire ALU_Z_I,
  input wire ALU_C_I,
  // core outputs
  output reg [7:0] STATUS_O,
  output reg [15:0] STACK_POINTER_O,
  output reg IRQ_ALLOW_O,
  output reg PROTECTED_IO_UNLOCK_O,
  output reg SELF_PROGRAM_UNLOCK_O
);
  reg [2:0] state_r, state_nxt;
  reg [2:0] win_cnt_r, win_cnt_nxt;
  reg [2:0] spl_cnt_r, spl_cnt_nxt;
  reg [7:0] temp_r;
  reg [15:0] sp_r, sp_nxt;
  reg [7:0] status_flags_r, status_flags_nxt;
  reg wait_r;
  reg [7:0] rdata_nxt;

  function hit;
    input [5:0] a;
    input [5:0] b;
    hit = (a == b);
  endfunction

  wire wr_unlock = IO_WE_I && hit(IO_ADDR_I, `CPSS_OFS_UNLOCK);
  wire wr_spl = IO_WE_I && hit(IO_ADDR_I, `CPSS_OFS_SPL);
  wire wr_sph = IO_WE_I && hit(IO_ADDR_I, `CPSS_OFS_SPH);
  wire wr_status_flags = IO_WE_I && hit(IO_ADDR_I, `CPSS_OFS_STATUS);
  wire [15:0] sp_mask = (SP_BITS >= 16) ? 16'hffff : ((16'h0001 << SP_BITS) - 16'h0001);
  wire i_change = wr_status_flags && (IO_WDATA_I[`CPSS_BIT_I] != status_flags_r[`CPSS_BIT_I]);
  // a stalled access is accepted once; the wait cycle only holds the core
  wire wr_ok = !wait_r;

  // unlock window
  always @* begin
    state_nxt = state_r;
    win_cnt_nxt = win_cnt_r;
    case (state_r)
      `CPSS_ST_IDLE: begin
      end
      `CPSS_ST_IO: begin
        if (INSTR_DONE_I)
          win_cnt_nxt = win_cnt_r - 3'h1; // R01
        if ((INSTR_DONE_I && win_cnt_r == 3'h1) || (IO_WE_I && !wr_unlock) || DMEM_WE_I
            || NVM_ACCESS_I || SLEEP_I)
          state_nxt = `CPSS_ST_IDLE; // R20
      end
      `CPSS_ST_SPM: begin
        if (INSTR_DONE_I)
          win_cnt_nxt = win_cnt_r - 3'h1;
        if ((INSTR_DONE_I && win_cnt_r == 3'h1) || NVM_ACCESS_I || SLEEP_I)
          state_nxt = `CPSS_ST_IDLE;
      end
      default: state_nxt = `CPSS_ST_IDLE;
    endcase
    if (wr_unlock && wr_ok) begin
      if (IO_WDATA_I == `CPSS_KEY_IO) begin
        state_nxt = `CPSS_ST_IO; // R01
        win_cnt_nxt = `CPSS_WIN_INSTR;
      end else if (IO_WDATA_I == `CPSS_KEY_SPM) begin
        state_nxt = `CPSS_ST_SPM; // R01
        win_cnt_nxt = `CPSS_WIN_INSTR;
      end
      // any other value leaves the window as it was // R22
    end
    if (state_nxt == `CPSS_ST_IDLE)
      win_cnt_nxt = 3'h0;
  end

  // stack pointer and stack-write irq hold
  always @* begin
    sp_nxt = sp_r;
    spl_cnt_nxt = spl_cnt_r;
    if (spl_cnt_r != 3'h0) begin
      if (IO_WE_I || DMEM_WE_I)
        spl_cnt_nxt = 3'h0; // R08
      else if (INSTR_DONE_I)
        spl_cnt_nxt = spl_cnt_r - 3'h1; // R08
    end
    if (wr_spl && wr_ok)
      spl_cnt_nxt = `CPSS_WIN_INSTR; // R08
    if (wr_sph && wr_ok)
      sp_nxt = {IO_WDATA_I, temp_r} & sp_mask; // R21 R06
  end

  // status register
  always @* begin
    status_flags_nxt = status_flags_r;
    if (ALU_UPD_I) begin
      if (ALU_UPD_MASK_I[4]) begin
        status_flags_nxt[`CPSS_BIT_H] = ALU_H_I; // R14
      end
      if (ALU_UPD_MASK_I[3]) begin
        status_flags_nxt[`CPSS_BIT_V] = ALU_V_I; // R16
      end
      if (ALU_UPD_MASK_I[2]) begin
        status_flags_nxt[`CPSS_BIT_N] = ALU_N_I; // R17
      end
      if (ALU_UPD_MASK_I[1]) begin
        status_flags_nxt[`CPSS_BIT_Z] = ALU_Z_I; // R18
      end
      if (ALU_UPD_MASK_I[0]) begin
        status_flags_nxt[`CPSS_BIT_C] = ALU_C_I; // R19
      end
    end
    if (BIT_STORE_INSTR_I) begin
      status_flags_nxt[`CPSS_BIT_T] = BIT_STORE_VAL_I; // R13
    end
    // the held second cycle of an enable-changing write is the one that lands
    if (wr_status_flags && (wait_r || !i_change)) begin
      status_flags_nxt = IO_WDATA_I; // R09 R12
    end
    if (IRQ_ENABLE_INSTR_I)
      status_flags_nxt[`CPSS_BIT_I] = 1'b1; // R11
    if (IRQ_DISABLE_INSTR_I)
      status_flags_nxt[`CPSS_BIT_I] = 1'b0; // R11
    // no irq entry or return input touches the enable bit // R10
    status_flags_nxt[`CPSS_BIT_S] = status_flags_nxt[`CPSS_BIT_N] ^ status_flags_nxt[`CPSS_BIT_V]; // R15
  end

  // read mux, registered
  always @* begin
    rdata_nxt = 8'h00;
    if (hit(IO_ADDR_I, `CPSS_OFS_UNLOCK))
      rdata_nxt = {6'h00, state_r == `CPSS_ST_SPM, state_r == `CPSS_ST_IO}; // R03 R04
    else if (hit(IO_ADDR_I, `CPSS_OFS_SPL))
      rdata_nxt = sp_r[7:0]; // R07
    else if (hit(IO_ADDR_I, `CPSS_OFS_SPH))
      rdata_nxt = sp_r[15:8]; // R07
    else if (hit(IO_ADDR_I, `CPSS_OFS_STATUS))
      rdata_nxt = status_flags_r;
  end

  // unlock window registers
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      state_r <= `CPSS_ST_IDLE;
      win_cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      win_cnt_r <= win_cnt_nxt;
    end
  end

  // stack pointer, its temp byte and the stack-write irq hold
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      spl_cnt_r <= 3'h0;
      temp_r <= 8'h00;
      sp_r <= SRAM_TOP & sp_mask; // R05
    end else begin
      spl_cnt_r <= spl_cnt_nxt;
      if (wr_spl && wr_ok) begin
        temp_r <= IO_WDATA_I; // R21
      end
      sp_r <= sp_nxt;
    end
  end

  // status register and the enable-change stall
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      status_flags_r <= `CPSS_STATUS_RESET;
      wait_r <= 1'b0;
    end else begin
      status_flags_r <= status_flags_nxt;
      // first cycle of an enable-changing write stalls, the second commits
      wait_r <= i_change && !wait_r; // R12
    end
  end

  // bus answers
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      IO_RDATA_O <= 8'h00;
      IO_WAIT_O <= 1'b0;
    end else begin
      IO_WAIT_O <= i_change && !wait_r; // R12
      IO_RDATA_O <= IO_RE_I ? rdata_nxt : 8'h00;
    end
  end

  // core-facing copies, one cycle behind the next-state logic
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      STATUS_O <= `CPSS_STATUS_RESET;
      STACK_POINTER_O <= SRAM_TOP & sp_mask;
      IRQ_ALLOW_O <= 1'b0;
      PROTECTED_IO_UNLOCK_O <= 1'b0;
      SELF_PROGRAM_UNLOCK_O <= 1'b0;
    end else begin
      STATUS_O <= status_flags_nxt;
      STACK_POINTER_O <= sp_nxt;
      IRQ_ALLOW_O <= status_flags_nxt[`CPSS_BIT_I] && (state_nxt == `CPSS_ST_IDLE)
        && (spl_cnt_nxt == 3'h0); // R09 R02 R08
      PROTECTED_IO_UNLOCK_O <= state_nxt == `CPSS_ST_IO;
      SELF_PROGRAM_UNLOCK_O <= state_nxt == `CPSS_ST_SPM;
    end
  end
endmodule // cpss_core

// ==== dv/cpss_core_asserts.sv ====
`timescale 1ns/10ps
module cpss_chk #(parameter SP_BITS = 8) (
  input wire CLK_I, input wire SRST_I, input wire IO_WE_I,
  input wire [5:0] IO_ADDR_I, input wire [7:0] IO_WDATA_I,
  input wire DMEM_WE_I, input wire NVM_ACCESS_I, input wire SLEEP_I, input wire IO_WAIT_O,
  input wire [7:0] STATUS_O, input wire [15:0] STACK_POINTER_O, input wire IRQ_ALLOW_O,
  input wire PROTECTED_IO_UNLOCK_O, input wire SELF_PROGRAM_UNLOCK_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire key_w = IO_WE_I && IO_ADDR_I == 6'h04;
  wire win = PROTECTED_IO_UNLOCK_O || SELF_PROGRAM_UNLOCK_O;
  chk_io_key: assert property (key_w && IO_WDATA_I == 8'hd8 |=> PROTECTED_IO_UNLOCK_O)
    else $error("io unlock did not open");
  chk_spm_key: assert property (key_w && IO_WDATA_I == 8'h9d |=> SELF_PROGRAM_UNLOCK_O)
    else $error("spm unlock did not open");
  chk_bad_key: assert property (key_w && IO_WDATA_I != 8'hd8 && IO_WDATA_I != 8'h9d
    && !win |=> !win)
    else $error("bad key opened a window");
  chk_irq_hold: assert property (win && $past(win) |-> !IRQ_ALLOW_O)
    else $error("irq allowed in window");
  chk_sign_xor: assert property (STATUS_O[4] == (STATUS_O[2] ^ STATUS_O[3]))
    else $error("sign flag wrong");
  chk_gie_wait: assert property (IO_WE_I && IO_ADDR_I == 6'h0f && !IO_WAIT_O
    && IO_WDATA_I[7] != STATUS_O[7] |=> IO_WAIT_O)
    else $error("no wait on enable change");
  chk_io_kill: assert property (PROTECTED_IO_UNLOCK_O && !IO_WE_I
    && (DMEM_WE_I || NVM_ACCESS_I || SLEEP_I) |=> !PROTECTED_IO_UNLOCK_O)
    else $error("io unlock survived kill");
  chk_sp_unused: assert property ((STACK_POINTER_O >> SP_BITS) == 16'h0000)
    else $error("unused stack bits set");
endmodule // cpss_chk
bind cpss_core cpss_chk #(.SP_BITS(SP_BITS)) u_chk (.CLK_I, .SRST_I, .IO_WE_I, .IO_ADDR_I,
  .IO_WDATA_I, .DMEM_WE_I, .NVM_ACCESS_I, .SLEEP_I, .IO_WAIT_O, .STATUS_O, .STACK_POINTER_O,
  .IRQ_ALLOW_O, .PROTECTED_IO_UNLOCK_O, .SELF_PROGRAM_UNLOCK_O);

// ==== dv/cpss_core_tb_top.sv ====
`timescale 1ns/10ps
module cpss_core_tb_top;
  reg clk = 0, rst = 1, we = 0, re = 0, dm = 0, nvm = 0, slp = 0, en = 0, dis = 0;
  reg bit_store_instr = 0, bsv = 0, au = 0, run = 0, ws = 0;
  reg [5:0] addr = 0;
  reg [7:0] wd = 0;
  reg [4:0] am = 0, av = 0;
  reg [27:0] rows [0:5];
  wire [7:0] rd, st;
  wire [15:0] sp;
  wire wt, ia, pu, su, done;
  integer fails = 0, n_checks = 0, cyc = 0, i;
  cpss_exec_model u_model (.clk_i(clk), .rst_i(rst), .run_i(run), .instr_done_o(done));
  cpss_core #(.SP_BITS(8), .SRAM_TOP(16'h00ff)) dut (.CLK_I(clk), .SRST_I(rst), .IO_WE_I(we),
    .IO_RE_I(re), .IO_ADDR_I(addr), .IO_WDATA_I(wd), .IO_RDATA_O(rd), .IO_WAIT_O(wt),
    .INSTR_DONE_I(done), .DMEM_WE_I(dm), .NVM_ACCESS_I(nvm), .SLEEP_I(slp),
    .IRQ_ENABLE_INSTR_I(en), .IRQ_DISABLE_INSTR_I(dis), .BIT_STORE_INSTR_I(bit_store_instr),
    .BIT_STORE_VAL_I(bsv), .ALU_UPD_I(au), .ALU_UPD_MASK_I(am), .ALU_H_I(av[4]),
    .ALU_V_I(av[3]), .ALU_N_I(av[2]), .ALU_Z_I(av[1]), .ALU_C_I(av[0]), .STATUS_O(st),
    .STACK_POINTER_O(sp), .IRQ_ALLOW_O(ia), .PROTECTED_IO_UNLOCK_O(pu),
    .SELF_PROGRAM_UNLOCK_O(su));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick;
    begin @(posedge clk); #1; end
  endtask
  // a changed enable bit stalls one cycle, so the write is held over
  task wr(input [5:0] a, input [7:0] d);
    begin addr = a; wd = d; we = 1; tick; ws = wt; if (wt === 1'b1) tick; we = 0; end
  endtask
  task rc(input [5:0] a, input [7:0] e);
    begin addr = a; re = 1; tick; re = 0; chk(rd, e); end
  endtask
  task reset_run;
    begin rst = 1; repeat (12) tick; rst = 0; chk(st, 0); chk(sp, 16'h00ff); end
  endtask
  task results;
    begin
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin fails = fails + 1; results; end
  end
  initial begin
    rows[0] = {6'h04, 8'hd8, 6'h04, 8'h01}; rows[1] = {6'h04, 8'h9d, 6'h04, 8'h02};
    rows[2] = {6'h04, 8'h55, 6'h04, 8'h00}; rows[3] = {6'h0f, 8'h4c, 6'h0f, 8'h4c};
    rows[4] = {6'h0f, 8'h44, 6'h0f, 8'h54}; rows[5] = {6'h0f, 8'h08, 6'h0f, 8'h18};
    reset_run;
    for (i = 0; i < 6; i = i + 1) begin
      wr(rows[i][27:22], rows[i][21:14]);
      rc(rows[i][13:8], rows[i][7:0]);
      run = 1; repeat (12) tick; run = 0;
    end
    $display("table done");
    wr(6'h0d, 8'h34); chk(sp, 16'h00ff);
    wr(6'h0e, 8'h12); chk(sp, 16'h0034);
    rc(6'h0e, 8'h00); rc(6'h0d, 8'h34);
    wr(6'h0f, 8'h80); chk(ws, 1); chk(st[7], 1); tick; chk(ia, 1);
    wr(6'h0d, 8'h34); tick; chk(ia, 0); dm = 1; tick; dm = 0; tick; chk(ia, 1);
    wr(6'h04, 8'hd8); tick; chk(ia, 0);
    slp = 1; tick; slp = 0; tick; chk(pu, 0); chk(ia, 1);
    dis = 1; tick; dis = 0; chk(st[7], 0); en = 1; tick; en = 0; chk(st[7], 1);
    au = 1; am = 5'h1f; av = 5'b11011; tick; chk(st, 8'hbb);
    av = 5'b00100; tick; au = 0; chk(st, 8'h94);
    bit_store_instr = 1; bsv = 1; tick; bit_store_instr = 0; chk(st[6], 1);
    $display("hand tests done");
    reset_run;
    results;
  end
endmodule // cpss_core_tb_top

// ==== dv/cpss_exec_model.sv ====
`timescale 1ns/10ps
module cpss_exec_model (
  input wire clk_i, input wire rst_i, input wire run_i,
  output reg instr_done_o
);
  // slow core: one instruction every second cycle keeps windows open longer
  always @(posedge clk_i) begin
    instr_done_o <= !rst_i && run_i && !instr_done_o;
  end
endmodule // cpss_exec_model

// ==== pkg/cpss_defs.vh ====
`ifndef CPSS_DEFS_VH
`define CPSS_DEFS_VH
`define CPSS_OFS_UNLOCK 6'h04
`define CPSS_OFS_SPL 6'h0d
`define CPSS_OFS_SPH 6'h0e
`define CPSS_OFS_STATUS 6'h0f
`define CPSS_KEY_IO 8'hd8
`define CPSS_KEY_SPM 8'h9d
`define CPSS_UNLOCK_RESET 8'h00
`define CPSS_STATUS_RESET 8'h00
`define CPSS_WIN_INSTR 3'h4
`define CPSS_BIT_I 7
`define CPSS_BIT_T 6
`define CPSS_BIT_H 5
`define CPSS_BIT_S 4
`define CPSS_BIT_V 3
`define CPSS_BIT_N 2
`define CPSS_BIT_Z 1
`define CPSS_BIT_C 0
`define CPSS_ST_IDLE 3'b001
`define CPSS_ST_IO 3'b010
`define CPSS_ST_SPM 3'b100
`endif
